//--- dsa_access_unit.sv
// Purpose: Load/store access logic for the 16-bit byte-addressed data space
// Assumes: Memory and special register read data arrive in the request cycle
// Notes: Results and trap indication are registered one cycle after the request
//
// What this block does
// [R1] Post-increment steps pointer by one for bytes, two for words.
// [R2] Byte read fetches whole word, picks byte by address bit 0, returns low.
// [R3] Byte write enables only the lane matching the byte address.
// [R4] Word access to an odd address raises an address error trap.
// [R5] Misaligned read still completes, then the trap is taken.
// [R6] Misaligned write executes but its memory write is suppressed.
// [R7] Byte load into a working register changes only its low byte.
// [R8] Sign extension copies bit 7 into the high byte.
// [R9] Zero extension clears the high byte.
// [R10] Addresses up to the first four kilobytes decode as special registers.
// [R11] Unused special register addresses read as zero.
// [R12] Thirteen-bit direct field reaches the eight-kilobyte near region.
// [R13] Sixteen-bit direct or indirect addressing reaches the whole space.
// [R14] Two generators with separate paths fetch two words in one cycle.
// [R15] X has separate read and write buses; X read serves combined reads.
// [R16] Multiply-accumulate ops read a Y operand alongside the X read.
// [R17] Modulo in X and Y, bit-reverse only on X writes, none without DSP.
// [R18] Every write decodes against the unified X plus Y range.
// [R19] The X/Y split is a fixed constant.
// [R20] Effective addresses are 16 bits and address bytes.
// [R21] Low byte at even address, high byte at odd address.
// [R22] Access beyond implemented memory returns zero.
// [R23] Alignment fault gives a one-cycle error pulse with the faulting address.
`timescale 1ns/10ps
module dsa_access_unit import dsa_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire dsa_req_type req_in,
	input wire dsa_mod_type xmod_in,
	input wire dsa_mod_type ymod_in,
	input wire logic [15:0] xr_data_in,
	input wire logic [15:0] yr_data_in,
	input wire logic [15:0] sfr_rd_data_in,
	input wire logic sfr_hit_in,
	input wire dsa_wop_type wop_in,
	input wire logic [15:0] wreg_in,
	output logic xr_en_out,
	output logic [15:0] xr_addr_out,
	output logic yr_en_out,
	output logic [15:0] yr_addr_out,
	output logic sfr_sel_out,
	output logic near_out,
	output dsa_wbus_type xw_out,
	output dsa_rsp_type rsp_out,
	output logic [15:0] wreg_out,
	output logic wreg_valid_out,
	output logic trap_out,
	output logic [15:0] fault_addr_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Address generators

	logic [15:0] g_ptr [2];
	logic g_byte [2];
	logic g_post [2];
	logic g_brev [2];
	dsa_mod_type g_mod [2];
	logic [15:0] g_ea [2];
	logic [15:0] g_next [2];

	always_comb begin
		g_ptr[0] = req_in.ptr;
		g_byte[0] = req_in.byte_op;
		g_post[0] = (req_in.mode == MODE_IND_POSTINC);
		g_brev[0] = req_in.write; // [R17]
		g_mod[0] = xmod_in;
		g_ptr[1] = req_in.yptr;
		g_byte[1] = 1'b0;
		g_post[1] = req_in.y_postinc;
		g_brev[1] = 1'b0;
		g_mod[1] = ymod_in;
	end

	// Index 0 is X, index 1 is Y; only X may step bit-reversed [R14]
	for (genvar gi = 0; gi < 2; gi++) begin : g_agen
		dsa_addr_gen #(
			.BITREV_OK(gi == 0)
		) u_gen (
			.ptr_in(g_ptr[gi]),
			.byte_op_in(g_byte[gi]),
			.postinc_in(g_post[gi]),
			.bitrev_req_in(g_brev[gi]),
			.mod_in(g_mod[gi]),
			.ea_out(g_ea[gi]),
			.next_ptr_out(g_next[gi])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	logic [15:0] ea;
	logic [15:0] word_addr;
	logic misalign;
	logic in_impl;
	logic in_sfr;
	logic y_in_range;

	always_comb begin
		case (req_in.mode)
			MODE_DIR16: begin
				ea = req_in.dir; // [R13]
			end
			MODE_DIR13: begin
				ea = {3'h0, req_in.dir[NEAR_FIELD_W-1:0]}; // [R12]
			end
			default: begin
				ea = g_ea[0]; // [R13] [R20]
			end
		endcase
		word_addr = {ea[15:1], 1'b0};
		misalign = req_in.valid && !req_in.byte_op && ea[0]; // [R4]
		in_impl = (ea <= IMPL_TOP); // [R18]
		in_sfr = (ea <= SFR_TOP); // [R10]
		y_in_range = (g_ea[1] >= Y_BASE) && (g_ea[1] <= IMPL_TOP); // [R19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus drive

	always_comb begin
		near_out = (ea <= NEAR_TOP);
		sfr_sel_out = req_in.valid && in_sfr; // [R10]
		// Combined-space reads outside the special register region go over the X read bus [R15]
		xr_en_out = req_in.valid && !req_in.write && in_impl && !in_sfr;
		xr_addr_out = word_addr;
		// Second operand fetched in parallel for the accumulate class [R16]
		yr_en_out = HAS_DSP && req_in.valid && req_in.mac && !req_in.write && y_in_range;
		yr_addr_out = {g_ea[1][15:1], 1'b0};
		xw_out.en = req_in.valid && req_in.write && in_impl && !misalign; // [R6] [R18]
		xw_out.addr = word_addr;
		if (req_in.byte_op) begin
			xw_out.be = ea[0] ? LANE_HIGH : LANE_LOW; // [R3] [R21]
			xw_out.data = {req_in.wdata[7:0], req_in.wdata[7:0]};
		end else begin
			xw_out.be = LANE_BOTH;
			xw_out.data = req_in.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data and working register

	logic [15:0] rd_word;
	logic [7:0] rd_byte;
	logic [15:0] rd_data;
	logic [15:0] y_data;
	logic [15:0] wreg_calc;

	always_comb begin
		if (!in_impl) begin
			rd_word = 16'h0000; // [R22]
		end else if (in_sfr) begin
			rd_word = sfr_hit_in ? sfr_rd_data_in : 16'h0000; // [R11]
		end else begin
			rd_word = xr_data_in;
		end
		rd_byte = ea[0] ? rd_word[15:8] : rd_word[7:0]; // [R2] [R21]
		rd_data = req_in.byte_op ? {8'h00, rd_byte} : rd_word; // [R2]
		y_data = yr_en_out ? yr_data_in : 16'h0000; // [R16]
		case (wop_in)
			WOP_BYTE_LOAD: begin
				wreg_calc = {wreg_in[15:8], rd_byte}; // [R7]
			end
			WOP_WORD_LOAD: begin
				wreg_calc = rd_word;
			end
			WOP_SIGN_EXT: begin
				wreg_calc = {{8{wreg_in[7]}}, wreg_in[7:0]}; // [R8]
			end
			WOP_ZERO_EXT: begin
				wreg_calc = {8'h00, wreg_in[7:0]}; // [R9]
			end
			default: begin
				wreg_calc = wreg_in;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered results

	dsa_rsp_type rsp_d;
	dsa_rsp_type rsp_q;
	logic trap_d;
	logic trap_q;
	logic [15:0] fault_d;
	logic [15:0] fault_q;
	logic [15:0] wreg_d;
	logic [15:0] wreg_q;
	logic wreg_valid_d;
	logic wreg_valid_q;

	always_comb begin
		// A faulting read still returns its data; the trap is registered in the same cycle as the data [R5]
		rsp_d.valid = req_in.valid && !req_in.write;
		rsp_d.rdata = rd_data;
		rsp_d.ydata = y_data;
		rsp_d.next_ptr = g_next[0]; // [R1]
		rsp_d.next_yptr = g_next[1];
		trap_d = misalign; // [R23]
		fault_d = misalign ? ea : fault_q; // [R23]
		wreg_valid_d = (wop_in != WOP_NONE);
		wreg_d = wreg_valid_d ? wreg_calc : wreg_q;
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rsp_q <= '0;
			trap_q <= 1'b0;
			fault_q <= 16'h0000;
			wreg_q <= 16'h0000;
			wreg_valid_q <= 1'b0;
		end else begin
			rsp_q <= rsp_d;
			trap_q <= trap_d;
			fault_q <= fault_d;
			wreg_q <= wreg_d;
			wreg_valid_q <= wreg_valid_d;
		end
	end

	always_comb begin
		rsp_out = rsp_q;
		trap_out = trap_q;
		fault_addr_out = fault_q;
		wreg_out = wreg_q;
		wreg_valid_out = wreg_valid_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_postinc_step: assert property ( // [R1]
		req_in.valid && (req_in.mode == MODE_IND_POSTINC) && !xmod_in.mod_en
		&& !(xmod_in.bitrev_en && req_in.write)
		|=> rsp_out.next_ptr == $past(req_in.ptr) + ($past(req_in.byte_op) ? 16'h0001 : 16'h0002))
		else $error("post-increment step wrong");

	a_byte_lane: assert property ( // [R3]
		xw_out.en && req_in.byte_op |-> xw_out.be == (ea[0] ? 2'h2 : 2'h1))
		else $error("byte write lane wrong");

	a_misalign_trap: assert property ( // [R4]
		req_in.valid && !req_in.byte_op && ea[0]
		|=> trap_out && (fault_addr_out == $past(ea)))
		else $error("misaligned word access not trapped");

	a_trap_cause: assert property ( // [R23]
		trap_out |-> $past(req_in.valid) && !$past(req_in.byte_op) && $past(ea[0]))
		else $error("trap without alignment fault");

	a_read_completes: assert property ( // [R5]
		req_in.valid && !req_in.write && misalign |=> rsp_out.valid)
		else $error("misaligned read did not complete");

	a_write_suppress: assert property ( // [R6]
		req_in.valid && req_in.write && !req_in.byte_op && ea[0] |-> !xw_out.en)
		else $error("misaligned write reached memory");

	a_sfr_unused: assert property ( // [R11]
		req_in.valid && !req_in.write && (ea <= 16'h0fff) && !sfr_hit_in
		|=> rsp_out.rdata == 16'h0000)
		else $error("unused special register not zero");

	a_beyond_zero: assert property ( // [R22]
		req_in.valid && !req_in.write && (ea > 16'hdfff) |=> rsp_out.rdata == 16'h0000)
		else $error("unimplemented address not zero");

	a_byte_read: assert property ( // [R2]
		req_in.valid && !req_in.write && req_in.byte_op && xr_en_out
		|=> rsp_out.rdata == {8'h00, $past(ea[0]) ? $past(xr_data_in[15:8]) : $past(xr_data_in[7:0])})
		else $error("byte read selection wrong");

	a_byte_load: assert property ( // [R7]
		wop_in == WOP_BYTE_LOAD |=> wreg_valid_out && (wreg_out[15:8] == $past(wreg_in[15:8])))
		else $error("byte load touched high byte");

	a_sign_ext: assert property ( // [R8]
		wop_in == WOP_SIGN_EXT |=> wreg_out == {{8{$past(wreg_in[7])}}, $past(wreg_in[7:0])})
		else $error("sign extension wrong");

	a_zero_ext: assert property ( // [R9]
		wop_in == WOP_ZERO_EXT |=> wreg_out == {8'h00, $past(wreg_in[7:0])})
		else $error("zero extension wrong");

	a_near_field: assert property ( // [R12]
		req_in.valid && (req_in.mode == MODE_DIR13)
		|-> near_out && (xr_addr_out == {3'h0, req_in.dir[12:1], 1'b0}))
		else $error("near field left near region");

	a_dual_fetch: assert property ( // [R16]
		req_in.valid && req_in.mac && !req_in.write && (g_ea[1] >= 16'h8000)
		&& (g_ea[1] <= 16'hdfff) |-> yr_en_out)
		else $error("second operand not fetched");

	c_misalign_read: cover property (req_in.valid && !req_in.write && misalign ##1 trap_out);
	c_misalign_write: cover property (req_in.valid && req_in.write && misalign);
	c_dual_fetch: cover property (xr_en_out && yr_en_out);
	c_byte_high_write: cover property (xw_out.en && (xw_out.be == 2'h2));

endmodule : dsa_access_unit

//--- dsa_pkg.sv
// Purpose: Shared constants and carrier types for the data space access unit
// Assumes: 16-bit byte-addressed data space, one core clock
// Notes: Region bounds and the X/Y split are fixed at build time
package dsa_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// Post-modify steps
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] WORD_STEP = 16'h0002;

	// Region bounds
	localparam logic [15:0] SFR_TOP = 16'h0fff;
	localparam logic [15:0] NEAR_TOP = 16'h1fff;
	localparam int NEAR_FIELD_W = 13;
	localparam logic [15:0] IMPL_TOP = 16'hdfff;
	// Start of Y space; fixed, software has no way to move it
	localparam logic [15:0] Y_BASE = 16'h8000;

	// Byte lane enables
	localparam logic [1:0] LANE_LOW = 2'h1;
	localparam logic [1:0] LANE_HIGH = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h3;

	// Set to 0 for variants without the signal processing engine
	localparam bit HAS_DSP = 1'b1;

	typedef enum logic [1:0] {
		MODE_DIR16,
		MODE_DIR13,
		MODE_IND,
		MODE_IND_POSTINC
	} dsa_mode_type;

	typedef enum logic [2:0] {
		WOP_NONE,
		WOP_BYTE_LOAD,
		WOP_WORD_LOAD,
		WOP_SIGN_EXT,
		WOP_ZERO_EXT
	} dsa_wop_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic byte_op;
		dsa_mode_type mode;
		logic [15:0] ptr;
		logic [15:0] dir;
		logic [15:0] wdata;
		logic mac;
		logic [15:0] yptr;
		logic y_postinc;
	} dsa_req_type;

	typedef struct packed {
		logic mod_en;
		logic [15:0] mod_start;
		logic [15:0] mod_end;
		logic bitrev_en;
		logic [15:0] bitrev_step;
	} dsa_mod_type;

	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [1:0] be;
		logic [15:0] data;
	} dsa_wbus_type;

	typedef struct packed {
		logic valid;
		logic [15:0] rdata;
		logic [15:0] ydata;
		logic [15:0] next_ptr;
		logic [15:0] next_yptr;
	} dsa_rsp_type;

endpackage : dsa_pkg

//--- dsa_addr_gen.sv
// Purpose: One address generator: effective address and post-modified pointer
// Assumes: Pointer post-increment only; pre-modify done by the pipeline
// Notes: Bit-reversed stepping only where the instance allows it
`timescale 1ns/10ps
module dsa_addr_gen import dsa_pkg::*; #(
	parameter bit BITREV_OK = 1'b0
) (
	input wire logic [15:0] ptr_in,
	input wire logic byte_op_in,
	input wire logic postinc_in,
	input wire logic bitrev_req_in,
	input wire dsa_mod_type mod_in,
	output logic [15:0] ea_out,
	output logic [15:0] next_ptr_out
);

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction : rev16

	logic [15:0] step;
	logic [15:0] inc;
	logic bitrev_on;

	always_comb begin
		step = byte_op_in ? BYTE_STEP : WORD_STEP;
		inc = ptr_in + step;
		bitrev_on = BITREV_OK && HAS_DSP && mod_in.bitrev_en && bitrev_req_in;
		ea_out = ptr_in;
		next_ptr_out = ptr_in;
		if (postinc_in) begin
			if (bitrev_on) begin
				// Reverse-carry add [R17]
				next_ptr_out = rev16(rev16(ptr_in) + rev16(mod_in.bitrev_step));
			end else if (HAS_DSP && mod_in.mod_en && (inc > mod_in.mod_end)) begin
				// Wrap back into the circular buffer [R17]
				next_ptr_out = mod_in.mod_start;
			end else begin
				next_ptr_out = inc; // [R1]
			end
		end
	end

endmodule : dsa_addr_gen

//--- dsa_mem_model.sv
// Purpose: Memory and special register model behind the access unit
// Assumes: Reads are combinational, writes land on the rising edge
// Notes: 512-byte alias; only the first 16 special register bytes exist
`timescale 1ns/10ps
module dsa_mem_model import dsa_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic xr_en_in,
	input wire logic [15:0] xr_addr_in,
	input wire logic yr_en_in,
	input wire logic [15:0] yr_addr_in,
	input wire logic sfr_sel_in,
	input wire dsa_wbus_type xw_in,
	output logic [15:0] xr_data_out,
	output logic [15:0] yr_data_out,
	output logic [15:0] sfr_rd_data_out,
	output logic sfr_hit_out
);
	logic [15:0] mem [256];
	logic [15:0] x_last_q;
	logic [15:0] y_last_q;
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = {~8'(i), 8'(i)};
		x_last_q = 16'h0000;
		y_last_q = 16'h0000;
	end
	// Released buses show the inverse of the last value, so a stale read cannot pass
	assign xr_data_out = xr_en_in ? mem[xr_addr_in[8:1]] : ~x_last_q;
	assign yr_data_out = yr_en_in ? mem[yr_addr_in[8:1]] : ~y_last_q;
	assign sfr_hit_out = sfr_sel_in && (xr_addr_in[15:4] == 12'h000);
	assign sfr_rd_data_out = sfr_hit_out ? mem[xr_addr_in[8:1]] : ~x_last_q;
	always @(posedge ref_clk_in) begin
		if (xr_en_in) x_last_q <= xr_data_out;
		if (yr_en_in) y_last_q <= yr_data_out;
		if (xw_in.en && xw_in.be[0]) mem[xw_in.addr[8:1]][7:0] <= xw_in.data[7:0];
		if (xw_in.en && xw_in.be[1]) mem[xw_in.addr[8:1]][15:8] <= xw_in.data[15:8];
	end
endmodule : dsa_mem_model

//--- test_data_space_access_unit.sv
// Purpose: Self-checking bench for the data space access unit
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Registered results are read one edge after the request
`timescale 1ns/10ps
module test_data_space_access_unit import dsa_pkg::*;;
	logic ref_clk_in;
	logic resetn_in;
	dsa_req_type req_in;
	dsa_mod_type xmod_in;
	dsa_mod_type ymod_in;
	logic [15:0] xr_data_in, yr_data_in, sfr_rd_data_in, wreg_in;
	logic sfr_hit_in;
	dsa_wop_type wop_in;
	logic xr_en_out, yr_en_out, sfr_sel_out, near_out, wreg_valid_out, trap_out;
	logic [15:0] xr_addr_out, yr_addr_out, wreg_out, fault_addr_out;
	dsa_wbus_type xw_out;
	dsa_rsp_type rsp_out;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	dsa_access_unit DUT (.ref_clk_in, .resetn_in, .req_in, .xmod_in, .ymod_in, .xr_data_in,
		.yr_data_in, .sfr_rd_data_in, .sfr_hit_in, .wop_in, .wreg_in, .xr_en_out, .xr_addr_out,
		.yr_en_out, .yr_addr_out, .sfr_sel_out, .near_out, .xw_out, .rsp_out, .wreg_out,
		.wreg_valid_out, .trap_out, .fault_addr_out);
	dsa_mem_model far (.ref_clk_in, .xr_en_in(xr_en_out), .xr_addr_in(xr_addr_out),
		.yr_en_in(yr_en_out), .yr_addr_in(yr_addr_out), .sfr_sel_in(sfr_sel_out),
		.xw_in(xw_out), .xr_data_out(xr_data_in), .yr_data_out(yr_data_in),
		.sfr_rd_data_out(sfr_rd_data_in), .sfr_hit_out(sfr_hit_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic dsa_req_type rq(input logic w, input logic b, input dsa_mode_type m,
		input logic [15:0] a, input logic [15:0] d);
		dsa_req_type r;
		r = '0;
		r.valid = 1'b1;
		r.write = w;
		r.byte_op = b;
		r.mode = m;
		r.ptr = a;
		r.dir = a;
		r.wdata = d;
		return r;
	endfunction : rq
	// Combinational outputs are settled 3 ns after the edge
	task automatic put(input dsa_req_type r, input dsa_wop_type w, input logic [15:0] wr);
		@(posedge ref_clk_in);
		#1;
		req_in = r;
		wop_in = w;
		wreg_in = wr;
		#2;
	endtask : put
	task automatic fin();
		@(posedge ref_clk_in);
		#1;
		req_in = '0;
		wop_in = WOP_NONE;
		#2;
	endtask : fin
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_lanes();
		put(rq(1'b1, 1'b0, MODE_IND, 16'h1100, 16'h1234), WOP_NONE, 16'h0000);
		chk("word be", {14'h0, xw_out.be}, {14'h0, LANE_BOTH});
		fin();
		put(rq(1'b1, 1'b1, MODE_IND_POSTINC, 16'h1101, 16'h00ab), WOP_NONE, 16'h0000);
		chk("byte be", {14'h0, xw_out.be}, {14'h0, LANE_HIGH});
		chk("byte hi data", {8'h00, xw_out.data[15:8]}, 16'h00ab);
		fin();
		chk("byte step", rsp_out.next_ptr, 16'h1102);
		put(rq(1'b0, 1'b1, MODE_IND, 16'h1101, 16'h0000), WOP_BYTE_LOAD, 16'h5a5a);
		fin();
		chk("odd byte rd", rsp_out.rdata, 16'h00ab);
		chk("byte load", wreg_out, 16'h5aab);
		chk("odd byte trap", {15'h0, trap_out}, 16'h0000);
		put(rq(1'b0, 1'b1, MODE_IND, 16'h1100, 16'h0000), WOP_NONE, 16'h0000);
		fin();
		chk("even byte rd", rsp_out.rdata, 16'h0034);
		put(rq(1'b0, 1'b0, MODE_IND_POSTINC, 16'h1100, 16'h0000), WOP_NONE, 16'h0000);
		fin();
		chk("word rd", rsp_out.rdata, 16'hab34);
		chk("word step", rsp_out.next_ptr, 16'h1102);
	endtask : t_lanes
	task automatic t_ext();
		dsa_wop_type ops [3] = '{WOP_SIGN_EXT, WOP_SIGN_EXT, WOP_ZERO_EXT};
		logic [15:0] ins [3] = '{16'h1280, 16'h8f7f, 16'h12f0};
		logic [15:0] exps [3] = '{16'hff80, 16'h007f, 16'h00f0};
		for (int i = 0; i < 3; i++) begin
			put('0, ops[i], ins[i]);
			fin();
			chk("extend", wreg_out, exps[i]);
			chk("extend valid", {15'h0, wreg_valid_out}, 16'h0001);
		end
	endtask : t_ext
	task automatic t_fault();
		put(rq(1'b0, 1'b0, MODE_IND, 16'h1101, 16'h0000), WOP_NONE, 16'h0000);
		chk("odd rd runs", {15'h0, xr_en_out}, 16'h0001);
		fin();
		chk("rd trap", {15'h0, trap_out}, 16'h0001);
		chk("rd completes", {15'h0, rsp_out.valid}, 16'h0001);
		chk("rd fault addr", fault_addr_out, 16'h1101);
		put(rq(1'b1, 1'b0, MODE_IND, 16'h1103, 16'hffff), WOP_NONE, 16'h0000);
		chk("odd wr held", {15'h0, xw_out.en}, 16'h0000);
		chk("trap one cycle", {15'h0, trap_out}, 16'h0000);
		fin();
		chk("wr trap", {15'h0, trap_out}, 16'h0001);
		chk("wr fault addr", fault_addr_out, 16'h1103);
		put(rq(1'b0, 1'b0, MODE_IND, 16'h1102, 16'h0000), WOP_NONE, 16'h0000);
		fin();
		chk("word kept", rsp_out.rdata, 16'h7e81);
	endtask : t_fault
	task automatic t_regions();
		put(rq(1'b0, 1'b1, MODE_DIR16, 16'h0800, 16'h0000), WOP_NONE, 16'h0000);
		chk("sfr sel", {15'h0, sfr_sel_out}, 16'h0001);
		fin();
		chk("sfr unused", rsp_out.rdata, 16'h0000);
		put(rq(1'b0, 1'b0, MODE_DIR16, 16'h0004, 16'h0000), WOP_WORD_LOAD, 16'h1111);
		chk("sfr hit sel", {15'h0, sfr_sel_out}, 16'h0001);
		fin();
		chk("sfr rd", rsp_out.rdata, 16'hfd02);
		chk("word load", wreg_out, 16'hfd02);
		put(rq(1'b0, 1'b0, MODE_DIR13, 16'hf800, 16'h0000), WOP_NONE, 16'h0000);
		chk("near", {15'h0, near_out}, 16'h0001);
		chk("near addr", xr_addr_out, 16'h1800);
		chk("not sfr", {15'h0, sfr_sel_out}, 16'h0000);
		fin();
		put(rq(1'b0, 1'b0, MODE_DIR16, 16'h9102, 16'h0000), WOP_NONE, 16'h0000);
		chk("far addr", xr_addr_out, 16'h9102);
		chk("far not near", {15'h0, near_out}, 16'h0000);
		fin();
		chk("far rd", rsp_out.rdata, 16'h7e81);
		put(rq(1'b0, 1'b0, MODE_DIR16, 16'he000, 16'h0000), WOP_NONE, 16'h0000);
		fin();
		chk("beyond rd", rsp_out.rdata, 16'h0000);
		put(rq(1'b1, 1'b0, MODE_DIR16, 16'h9104, 16'h4321), WOP_NONE, 16'h0000);
		chk("y space wr", {15'h0, xw_out.en}, 16'h0001);
		fin();
		put(rq(1'b1, 1'b0, MODE_DIR16, 16'he000, 16'h4321), WOP_NONE, 16'h0000);
		chk("beyond wr", {15'h0, xw_out.en}, 16'h0000);
		fin();
	endtask : t_regions
	// Addressing set-up changes on the same stimulus delay as every other input
	task automatic cfg(input dsa_mod_type m);
		@(posedge ref_clk_in);
		#1;
		xmod_in = m;
	endtask : cfg
	task automatic t_mac();
		dsa_req_type r;
		dsa_mod_type m;
		r = rq(1'b0, 1'b0, MODE_IND_POSTINC, 16'h1100, 16'h0000);
		r.mac = 1'b1;
		r.yptr = 16'h8004;
		r.y_postinc = 1'b1;
		m = '0;
		m.mod_en = 1'b1;
		m.mod_start = 16'h1100;
		m.mod_end = 16'h1101;
		cfg(m);
		put(r, WOP_NONE, 16'h0000);
		chk("dual x", {15'h0, xr_en_out}, 16'h0001);
		chk("dual y", {15'h0, yr_en_out}, 16'h0001);
		chk("y addr", yr_addr_out, 16'h8004);
		fin();
		chk("x operand", rsp_out.rdata, 16'hab34);
		chk("y operand", rsp_out.ydata, 16'hfd02);
		chk("y step", rsp_out.next_yptr, 16'h8006);
		chk("x wrap", rsp_out.next_ptr, 16'h1100);
		m = '0;
		m.bitrev_en = 1'b1;
		m.bitrev_step = 16'h0008;
		cfg(m);
		put(rq(1'b1, 1'b0, MODE_IND_POSTINC, 16'h1108, 16'h5678), WOP_NONE, 16'h0000);
		chk("brev wr addr", xw_out.addr, 16'h1108);
		chk("brev wr data", xw_out.data, 16'h5678);
		fin();
		chk("brev wr step", rsp_out.next_ptr, 16'h1104);
		put(rq(1'b0, 1'b0, MODE_IND_POSTINC, 16'h1108, 16'h0000), WOP_NONE, 16'h0000);
		fin();
		chk("brev rd step", rsp_out.next_ptr, 16'h110a);
		chk("brev rd data", rsp_out.rdata, 16'h5678);
		cfg('0);
	endtask : t_mac
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("Checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	// The whole run needs about 47 cycles; a hang is cut well after that
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		resetn_in = 1'b0;
		req_in = '0;
		xmod_in = '0;
		ymod_in = '0;
		wop_in = WOP_NONE;
		wreg_in = 16'h0000;
		repeat (2) @(posedge ref_clk_in);
		#1;
		resetn_in = 1'b1;
		t_lanes();
		t_ext();
		t_fault();
		t_regions();
		t_mac();
		conclude();
	end
endmodule : test_data_space_access_unit
